// ===== core/sgx_consts.svh
/*
 Constants of the serial GPIO expander: command codes, reset values,
 the slave address base and the bus spike filter timing.
 Assumes a single inclusion point per file; guarded against repeats.
*/
// ===========================================
// How it works
// (RULE1) first byte after address selects register
// (RULE2) codes 0..3: input, output, invert, direction
// (RULE3) input register tracks every pin level
// (RULE4) writes to input register are acked, ignored
// (RULE5) alert while input differs from register
// (RULE6) power-on reset loads defaults, idles bus
// (RULE7) reset pin does the same initialization
// (RULE8) two select pins alter slave address
// (RULE9) input register bits invertible per bit
// (RULE10) direction register sets each pin's direction
// (RULE11) all four registers readable by master
// (RULE12) after reset all pins are inputs
// (RULE13) output register drives output pins
// (RULE14) serial clock static up to 400 kHz
// (RULE15) glitch filter on clock and data inputs
// (RULE16) alert is active low open drain
// (RULE17) direction 0 drives, 1 is input
// (RULE18) invert bit 1 inverts, 0 keeps
// (RULE19) alert clears on return or input read
// (RULE20) pointer never auto-increments
// (RULE21) acknowledge only own address
`ifndef SGX_CONSTS_SVH
`define SGX_CONSTS_SVH

// ===========================================
// command codes (register selectors)
`define SGX_CMD_INPUT 2'h0
`define SGX_CMD_OUTPUT 2'h1
`define SGX_CMD_INVERT 2'h2
`define SGX_CMD_DIR 2'h3

// ===========================================
// register reset values
`define SGX_RST_OUTPUT 8'hFF
`define SGX_RST_INVERT 8'h00
`define SGX_RST_DIR 8'hFF

// ===========================================
// fixed upper slave address bits (value is arbitrary)
`define SGX_FIXED_ADDR 5'h15

// ===========================================
// spike filter: suppression time and link sample clock period
`define SGX_SPIKE_NS 50
`define SGX_LINK_PERIOD_PS 12000
`define SGX_FILT_CYC ((`SGX_SPIKE_NS * 1000 + `SGX_LINK_PERIOD_PS - 1) / `SGX_LINK_PERIOD_PS)

`endif

// ===== core/sgx_pkg.sv
/*
 Types shared by the serial GPIO expander: byte type, the configuration
 word that crosses into the core clock domain, and the bus engine states.
 Assumes nothing of its surroundings.
*/
package sgx_pkg;

   // ===========================================
   // plain byte of port data
   typedef logic [7:0] sgx_byte_t;

   // ===========================================
   // configuration word carried to the pin logic
   typedef struct packed {
      sgx_byte_t out_lvl; // output levels
      sgx_byte_t dir; // 1 = input, 0 = output
   } sgx_cfg_t;

   // ===========================================
   // serial bus engine states
   typedef enum logic [3:0] {
      SGX_IDLE,
      SGX_ADDR,
      SGX_ADDR_ACK,
      SGX_CMD,
      SGX_CMD_ACK,
      SGX_WDATA,
      SGX_WDATA_ACK,
      SGX_RDATA,
      SGX_MACK
   } sgx_state_t;

endpackage

// ===== core/sgx_expander.sv
/*
 Eight-bit GPIO expander behind a two-wire serial slave. The bus engine and
 the four registers run on link_clk_in, a fast sampling clock for the bus
 pins. Pin drive, input sampling and the alert output run on clock_in.
 Assumes open-drain wires are resolved outside from the *_oe_n_out enables,
 and that link_clk_in runs freely (it oversamples the serial lines).
*/
`include "sgx_consts.svh"

module sgx_expander #(
   parameter logic [4:0] FIXED_ADDR = `SGX_FIXED_ADDR
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic addr_sel_0_in,
   input wire logic addr_sel_1_in,
   input wire sgx_pkg::sgx_byte_t port_pin_in,
   output sgx_pkg::sgx_byte_t port_pin_out,
   output sgx_pkg::sgx_byte_t port_pin_oe_n_out,
   output logic alert_out,
   output logic alert_oe_n_out
);
   import sgx_pkg::*;

   // ===========================================
   // link domain: pin synchronisers and spike filters
   localparam logic [2:0] FILT_CYC = 3'(`SGX_FILT_CYC); // filter hold count

   logic [3:0] lk_s1_r; // first stage, read only by second stage
   logic [3:0] lk_s2_r; // {addr_sel_1, addr_sel_0, scl, sda}
   logic [1:0] flt_r; // filtered {scl, sda}
   logic [1:0] flt_d_r; // filtered, one cycle late
   logic [2:0] flt_cnt_r [2]; // stability counters

   // two-flop synchroniser for bus and address pins
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lk_s1_r <= 4'hF;
         lk_s2_r <= 4'hF;
      end else begin
         lk_s1_r <= {addr_sel_1_in, addr_sel_0_in, scl_in, sda_in};
         lk_s2_r <= lk_s1_r;
      end
   end

   // a line must hold a new level FILT_CYC samples before it is believed
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         always_ff @(posedge link_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               flt_r[gi] <= 1'b1;
               flt_cnt_r[gi] <= 3'h0;
            end else if (lk_s2_r[gi] == flt_r[gi]) begin
               flt_cnt_r[gi] <= 3'h0; // spike ended, restart
            end else if (flt_cnt_r[gi] == FILT_CYC - 3'h1) begin
               flt_r[gi] <= lk_s2_r[gi]; // RULE15
               flt_cnt_r[gi] <= 3'h0;
            end else begin
               flt_cnt_r[gi] <= flt_cnt_r[gi] + 3'h1;
            end
         end
      end
   endgenerate

   // delayed copy for edge detection
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flt_d_r <= 2'h3;
      end else begin
         flt_d_r <= flt_r;
      end
   end

   // ===========================================
   // link domain: bus conditions
   // edges are relative to the filtered lines, so any clock rate up to
   // the oversampling limit works, including a stopped clock
   wire scl_rise = flt_r[1] & ~flt_d_r[1]; // RULE14
   wire scl_fall = ~flt_r[1] & flt_d_r[1];
   wire scl_hi = flt_r[1] & flt_d_r[1];
   wire start_cond = scl_hi & flt_d_r[0] & ~flt_r[0];
   wire stop_cond = scl_hi & ~flt_d_r[0] & flt_r[0];
   wire sda_bit = flt_r[0];
   wire [6:0] own_addr = {FIXED_ADDR, lk_s2_r[3], lk_s2_r[2]}; // RULE8

   // ===========================================
   // link domain: engine registers
   sgx_state_t state_r, state_nxt; // bus engine state
   logic [3:0] cnt_r, cnt_nxt; // bits seen in current byte
   logic [7:0] shift_r, shift_nxt; // received bits
   logic [7:0] tx_r, tx_nxt; // bits still to send
   logic drv_n_r, drv_n_nxt; // low while pulling sda
   logic [1:0] ptr_r, ptr_nxt; // selected register
   logic rw_r, rw_nxt; // 1 = master reads
   logic wr_en; // one-cycle register write
   logic rd_in_evt; // input register loaded for sending
   logic rd_tog_r; // toggles on each input read
   sgx_byte_t out_r; // output levels register
   sgx_byte_t inv_r; // inversion mask register
   sgx_byte_t dir_r; // direction register
   sgx_byte_t in_lk_r; // pin levels seen from link side

   // ===========================================
   // link domain: read mux
   wire sgx_byte_t in_view = in_lk_r ^ inv_r; // RULE9 RULE18
   wire sgx_byte_t rd_byte = (ptr_r == `SGX_CMD_INPUT) ? in_view :
                             (ptr_r == `SGX_CMD_OUTPUT) ? out_r :
                             (ptr_r == `SGX_CMD_INVERT) ? inv_r : dir_r; // RULE11
   wire addr_hit = (shift_r[7:1] == own_addr);

   // bus engine next state; sda changes only on scl falling edges
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      drv_n_nxt = drv_n_r;
      ptr_nxt = ptr_r;
      rw_nxt = rw_r;
      wr_en = 1'b0;
      rd_in_evt = 1'b0;
      if (start_cond) begin
         // start or repeated start: listen for an address
         state_nxt = SGX_ADDR;
         cnt_nxt = 4'h0;
         drv_n_nxt = 1'b1;
      end else if (stop_cond) begin
         state_nxt = SGX_IDLE;
         drv_n_nxt = 1'b1;
      end else if (scl_rise) begin
         case (state_r)
            SGX_ADDR, SGX_CMD, SGX_WDATA: begin
               shift_nxt = {shift_r[6:0], sda_bit};
               cnt_nxt = cnt_r + 4'h1;
            end
            SGX_RDATA: begin
               cnt_nxt = cnt_r + 4'h1;
            end
            SGX_MACK: begin
               rw_nxt = sda_bit; // reuse as nack flag during read
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            SGX_ADDR: begin
               if (cnt_r == 4'h8) begin
                  if (addr_hit) begin
                     state_nxt = SGX_ADDR_ACK;
                     drv_n_nxt = 1'b0;
                     rw_nxt = shift_r[0];
                  end else begin
                     state_nxt = SGX_IDLE; // RULE21
                  end
               end
            end
            SGX_ADDR_ACK: begin
               cnt_nxt = 4'h0;
               if (rw_r) begin
                  // first data bit goes out right after the ack
                  state_nxt = SGX_RDATA;
                  drv_n_nxt = rd_byte[7];
                  tx_nxt = {rd_byte[6:0], 1'b1};
                  rd_in_evt = (ptr_r == `SGX_CMD_INPUT);
               end else begin
                  state_nxt = SGX_CMD; // RULE1
                  drv_n_nxt = 1'b1;
               end
            end
            SGX_CMD: begin
               if (cnt_r == 4'h8) begin
                  ptr_nxt = shift_r[1:0]; // RULE1 RULE2
                  state_nxt = SGX_CMD_ACK;
                  drv_n_nxt = 1'b0;
               end
            end
            SGX_CMD_ACK, SGX_WDATA_ACK: begin
               // further bytes go to the same register
               state_nxt = SGX_WDATA; // RULE20
               cnt_nxt = 4'h0;
               drv_n_nxt = 1'b1;
            end
            SGX_WDATA: begin
               if (cnt_r == 4'h8) begin
                  wr_en = 1'b1;
                  state_nxt = SGX_WDATA_ACK;
                  drv_n_nxt = 1'b0; // RULE4
               end
            end
            SGX_RDATA: begin
               if (cnt_r == 4'h8) begin
                  state_nxt = SGX_MACK;
                  drv_n_nxt = 1'b1;
               end else begin
                  drv_n_nxt = tx_r[7];
                  tx_nxt = {tx_r[6:0], 1'b1};
               end
            end
            SGX_MACK: begin
               cnt_nxt = 4'h0;
               if (!rw_r) begin
                  // master acked: resend the same register
                  state_nxt = SGX_RDATA; // RULE20
                  drv_n_nxt = rd_byte[7];
                  tx_nxt = {rd_byte[6:0], 1'b1};
                  rd_in_evt = (ptr_r == `SGX_CMD_INPUT);
                  rw_nxt = 1'b1;
               end else begin
                  state_nxt = SGX_IDLE;
               end
            end
            default: begin
               state_nxt = SGX_IDLE;
            end
         endcase
      end
   end

   // engine state flops
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= SGX_IDLE; // RULE6 RULE7
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'hFF;
         drv_n_r <= 1'b1;
         ptr_r <= `SGX_CMD_INPUT;
         rw_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         drv_n_r <= drv_n_nxt;
         ptr_r <= ptr_nxt;
         rw_r <= rw_nxt;
      end
   end

   // ===========================================
   // link domain: register file
   wire wr_out = wr_en & (ptr_r == `SGX_CMD_OUTPUT);
   wire wr_inv = wr_en & (ptr_r == `SGX_CMD_INVERT);
   wire wr_dir = wr_en & (ptr_r == `SGX_CMD_DIR); // RULE10

   // writes to the input selector fall through every decode
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_r <= `SGX_RST_OUTPUT; // RULE6 RULE7
         inv_r <= `SGX_RST_INVERT;
         dir_r <= `SGX_RST_DIR; // RULE12
         rd_tog_r <= 1'b0;
      end else begin
         out_r <= wr_out ? shift_r : out_r;
         inv_r <= wr_inv ? shift_r : inv_r;
         dir_r <= wr_dir ? shift_r : dir_r;
         rd_tog_r <= rd_tog_r ^ rd_in_evt;
      end
   end

   // sda output stage
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else begin
         sda_out <= 1'b0; // open drain: only ever pulls low
         sda_oe_n_out <= drv_n_nxt;
      end
   end

   // ===========================================
   // crossing: configuration words, link -> core (handshake loop)
   // the published copy only changes while no transfer is in flight,
   // so the core may take it whole once it sees the request flip
   wire sgx_cfg_t cfg_live = '{out_lvl: out_r, dir: dir_r};
   sgx_cfg_t cfg_pub_r; // stable while request is pending
   logic cfg_req_r; // link-side request toggle
   logic cfg_ack_r; // core-side acknowledge toggle
   logic [1:0] cfg_ack_sy_r; // ack synchroniser in link domain
   logic [1:0] cfg_req_sy_r; // req synchroniser in core domain
   sgx_cfg_t cfg_core_r; // configuration seen by the pin logic

   // link side of the configuration loop
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_pub_r <= '{out_lvl: `SGX_RST_OUTPUT, dir: `SGX_RST_DIR};
         cfg_req_r <= 1'b0;
         cfg_ack_sy_r <= 2'h0;
      end else begin
         cfg_ack_sy_r <= {cfg_ack_sy_r[0], cfg_ack_r};
         if (cfg_ack_sy_r[1] == cfg_req_r) begin
            cfg_pub_r <= cfg_live;
            cfg_req_r <= ~cfg_req_r;
         end
      end
   end

   // core side of the configuration loop
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_core_r <= '{out_lvl: `SGX_RST_OUTPUT, dir: `SGX_RST_DIR};
         cfg_ack_r <= 1'b0;
         cfg_req_sy_r <= 2'h0;
      end else begin
         cfg_req_sy_r <= {cfg_req_sy_r[0], cfg_req_r};
         if (cfg_req_sy_r[1] != cfg_ack_r) begin
            cfg_core_r <= cfg_pub_r;
            cfg_ack_r <= cfg_req_sy_r[1];
         end
      end
   end

   // ===========================================
   // core domain: port pins
   sgx_byte_t pin_s1_r; // first stage, read only by second stage
   sgx_byte_t pin_s2_r; // synchronised pin levels
   sgx_byte_t snap_r; // levels last handed to a reader
   logic [2:0] settle_r; // fills with ones after reset
   logic [2:0] rd_sy_r; // read toggle sync plus edge stage

   // pin synchroniser and read-event sync
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         rd_sy_r <= 3'h0;
      end else begin
         pin_s1_r <= port_pin_in;
         pin_s2_r <= pin_s1_r;
         rd_sy_r <= {rd_sy_r[1:0], rd_tog_r};
      end
   end

   // crossing: pin levels, core -> link (handshake loop)
   sgx_byte_t in_pub_r; // stable while request is pending
   logic in_req_r; // core-side request toggle
   logic in_ack_r; // link-side acknowledge toggle
   logic [1:0] in_ack_sy_r; // ack synchroniser in core domain
   logic [1:0] in_req_sy_r; // req synchroniser in link domain

   // core side of the pin level loop
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         in_pub_r <= 8'h00;
         in_req_r <= 1'b0;
         in_ack_sy_r <= 2'h0;
      end else begin
         in_ack_sy_r <= {in_ack_sy_r[0], in_ack_r};
         if (in_ack_sy_r[1] == in_req_r) begin
            in_pub_r <= pin_s2_r; // RULE3 RULE13
            in_req_r <= ~in_req_r;
         end
      end
   end

   // link side of the pin level loop
   always_ff @(posedge link_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         in_lk_r <= 8'h00;
         in_ack_r <= 1'b0;
         in_req_sy_r <= 2'h0;
      end else begin
         in_req_sy_r <= {in_req_sy_r[0], in_req_r};
         if (in_req_sy_r[1] != in_ack_r) begin
            in_lk_r <= in_pub_r;
            in_ack_r <= in_req_sy_r[1];
         end
      end
   end

   // ===========================================
   // core domain: change alert
   // an input register read rebases the reference; until the synchroniser has settled
   // after reset the reference tracks the pins, avoiding a false alert
   wire rd_seen = rd_sy_r[2] ^ rd_sy_r[1];
   wire sgx_byte_t diff = (pin_s2_r ^ snap_r) & cfg_core_r.dir;
   wire alert_now = |diff; // RULE5

   // reference capture for the alert compare
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         snap_r <= 8'h00;
         settle_r <= 3'h0;
      end else begin
         settle_r <= {settle_r[1:0], 1'b1};
         if (!settle_r[2] || rd_seen) begin
            snap_r <= pin_s2_r; // RULE19
         end
      end
   end

   // output flops for port pins and alert line
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_pin_out <= `SGX_RST_OUTPUT;
         port_pin_oe_n_out <= `SGX_RST_DIR; // RULE12
         alert_out <= 1'b0;
         alert_oe_n_out <= 1'b1;
      end else begin
         port_pin_out <= cfg_core_r.out_lvl; // RULE13
         port_pin_oe_n_out <= cfg_core_r.dir; // RULE17 RULE10
         alert_out <= 1'b0; // open drain: pulls low only
         alert_oe_n_out <= ~(alert_now & settle_r[2] & ~rd_seen); // RULE16 RULE19
      end
   end

endmodule

// ===== testbench/sgx_expander_assertions.sv
/*
 port checker of the serial GPIO expander.
 assumes it is bound to sgx_expander and sees only that module's ports.
*/
module sgx_expander_assertions (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n_out,
   input wire logic addr_sel_0_in,
   input wire logic addr_sel_1_in,
   input wire sgx_pkg::sgx_byte_t port_pin_in,
   input wire sgx_pkg::sgx_byte_t port_pin_out,
   input wire sgx_pkg::sgx_byte_t port_pin_oe_n_out,
   input wire logic alert_out,
   input wire logic alert_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import sgx_pkg::*;
   // ===========================================
   // helper: core cycles since scl was last low
   logic [7:0] scl_hi_r; // saturates so a parked bus cannot wrap it
   logic [7:0] scl_hi_nxt;
   assign scl_hi_nxt = !scl_in ? 8'h00 : ((scl_hi_r == 8'hFF) ? scl_hi_r : scl_hi_r + 8'h01);
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_hi_r <= 8'h00;
      end else begin
         scl_hi_r <= scl_hi_nxt;
      end
   end
   // ===========================================
   // assertions
   a_od_const: assert property (@(posedge clock_in) disable iff (!reset_n_in) !sda_out && !alert_out)
      else $error("open-drain output level not low");
   a_sda_scl_low: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
      $changed(sda_oe_n_out) |-> !scl_in) else $error("data line moved while clock high");
   a_rst_sda: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> sda_oe_n_out) else $error("data line held after reset");
   a_rst_dir: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> port_pin_oe_n_out == 8'hFF && port_pin_out == 8'hFF)
      else $error("pins not inputs after reset");
   a_rst_alert: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> alert_oe_n_out [*3]) else $error("alert right after reset");
   a_alert_cause: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $fell(alert_oe_n_out) |-> port_pin_oe_n_out != 8'h00 || $past(port_pin_oe_n_out, 4) != 8'h00)
      else $error("alert with no input pin");
   a_out_after_bus: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $changed(port_pin_out) |-> scl_hi_r < 8'h64) else $error("output levels moved without bus");
   a_dir_after_bus: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $changed(port_pin_oe_n_out) |-> scl_hi_r < 8'h64) else $error("directions moved without bus");
   // ===========================================
   // covers
   c_alert: cover property (@(posedge clock_in) disable iff (!reset_n_in) $fell(alert_oe_n_out));
   c_ack: cover property (@(posedge link_clk_in) disable iff (!reset_n_in) $fell(sda_oe_n_out));
   c_drive: cover property (@(posedge clock_in) disable iff (!reset_n_in) $changed(port_pin_out));
endmodule

// ===== testbench/sgx_bus_master.sv
/*
 timed two-wire bus master model driving clock and data levels.
 assumes the bench resolves the open-drain data wire with a pull-up.
*/
module sgx_bus_master (
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 625; // quarter bit, clock never above 400 kHz
   logic glitch_en; // bench sets it to add a 20 ns clock spike per bit
   // clock stands high and data released between frames
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      glitch_en = 1'b0;
   end
   task automatic start_c();
      #Q sda_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_out = 1'b0;
      #Q scl_out = 1'b0;
   endtask
   task automatic stop_c();
      #Q sda_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_out = 1'b1;
      #Q;
   endtask
   // eight bits msb first, then the acknowledge slot; sampled mid-high
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #Q sda_out = tx[i];
         if (glitch_en) begin
            scl_out = 1'b1;
            #20 scl_out = 1'b0;
         end
         #Q scl_out = 1'b1;
         #Q rx[i] = sda_in;
         #Q scl_out = 1'b0;
      end
   endtask
endmodule

// ===== testbench/tb_top.sv
/*
 self-checking bench of the serial GPIO expander.
 assumes the checker and the bus master model are compiled first.
*/
bind sgx_expander sgx_expander_assertions chk_u (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .link_clk_in(link_clk_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
   .addr_sel_0_in(addr_sel_0_in), .addr_sel_1_in(addr_sel_1_in), .port_pin_in(port_pin_in),
   .port_pin_out(port_pin_out), .port_pin_oe_n_out(port_pin_oe_n_out),
   .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out)
);
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sgx_pkg::*;
   localparam logic [4:0] FA = 5'h15; // fixed address bits, value arbitrary
   logic clock_in, reset_n_in, link_clk, m_scl, m_sda, sda_w, sda_o, sda_oe_n, al, al_oe_n;
   logic [1:0] sel; // address select pins
   sgx_byte_t pin_in, pin_out, pin_oe_n, ext, out_e, inv_e, dir_e; // ext = far-end pin levels
   sgx_byte_t exp_q[$], got_q[$]; // expected notes and observed results
   int err_count = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h0000BE3B;
   // ===========================================
   // open-drain wires: pull-up on data, pins driven where oe_n low
   assign sda_w = m_sda & (sda_oe_n | sda_o);
   assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
   sgx_expander #(.FIXED_ADDR(FA)) dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .link_clk_in(link_clk), .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .addr_sel_0_in(sel[0]), .addr_sel_1_in(sel[1]), .port_pin_in(pin_in), .port_pin_out(pin_out),
      .port_pin_oe_n_out(pin_oe_n), .alert_out(al), .alert_oe_n_out(al_oe_n));
   sgx_bus_master bus_u (.sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   // link clock unrelated in phase
   initial begin
      link_clk = 1'b0;
      #7;
      forever #6 link_clk = ~link_clk;
   end
   // ===========================================
   // helpers
   function automatic sgx_byte_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // expected input register: pin level, then per-bit inversion
   function automatic sgx_byte_t in_e();
      return ((dir_e & ext) | (~dir_e & out_e)) ^ inv_e;
   endfunction
   task automatic cmp(input sgx_byte_t e, input sgx_byte_t g);
      n_checks++;
      if (g !== e) begin
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
         err_count++;
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic look(input sgx_byte_t e, input sgx_byte_t g);
      exp_q.push_back(e);
      got_q.push_back(g);
   endtask
   // start and address byte (write), acknowledge noted
   task automatic probe(input logic [1:0] s, input logic e);
      logic [8:0] rx;
      bus_u.start_c();
      bus_u.xfer({FA, s, 2'b01}, rx);
      look({7'h00, e}, {7'h00, rx[0]});
   endtask
   task automatic bus_wr(input sgx_byte_t c, input sgx_byte_t d, input bit has_d);
      logic [8:0] rx;
      probe(sel, 1'b0);
      bus_u.xfer({c, 1'b1}, rx);
      if (has_d) begin
         bus_u.xfer({d, 1'b1}, rx);
      end
      bus_u.stop_c();
   endtask
   // one byte read, closed by a not-acknowledge
   task automatic bus_rd(input sgx_byte_t e);
      logic [8:0] rx;
      bus_u.start_c();
      bus_u.xfer({FA, sel, 2'b11}, rx);
      bus_u.xfer(9'h1FF, rx);
      bus_u.stop_c();
      look(e, rx[8:1]);
   endtask
   // ===========================================
   // result watcher and watchdog
   initial forever begin
      wait (got_q.size() > 0);
      cmp(exp_q.pop_front(), got_q.pop_front());
   end
   initial begin
      #3000000;
      err_count++;
      wrap_up();
   end
   // ===========================================
   // main sequence
   initial begin
      reset_n_in = 1'b0;
      sel = 2'h0;
      ext = 8'h00;
      out_e = 8'hFF;
      inv_e = 8'h00;
      dir_e = 8'hFF;
      wait_c(16);
      reset_n_in = 1'b1;
      ext = rnd();
      wait_c(20);
      bus_rd(in_e());
      look(8'hFF, pin_oe_n);
      for (int c = 1; c < 4; c++) begin
         bus_wr(c[7:0], 8'h00, 1'b0);
         bus_rd((c == 2) ? 8'h00 : 8'hFF);
         bus_rd((c == 2) ? 8'h00 : 8'hFF);
      end
      out_e = rnd();
      dir_e = rnd();
      bus_wr(8'h01, out_e, 1'b1);
      bus_wr(8'h03, dir_e, 1'b1);
      wait_c(20);
      look(out_e, pin_out);
      look(dir_e, pin_oe_n);
      bus_wr(8'h00, 8'h00, 1'b0);
      bus_rd(in_e());
      inv_e = rnd();
      bus_wr(8'h02, inv_e, 1'b1);
      bus_wr(8'hFC, 8'h00, 1'b0);
      bus_rd(in_e());
      // writing the input register must leave everything alone
      bus_wr(8'h00, ~out_e, 1'b1);
      bus_rd(in_e());
      look(out_e, pin_out);
      // spikes on the clock line must not add bits
      bus_u.glitch_en = 1'b1;
      bus_wr(8'h01, 8'hA5, 1'b1);
      bus_u.glitch_en = 1'b0;
      out_e = 8'hA5;
      bus_rd(out_e);
      for (int s = 0; s < 4; s++) begin
         @(negedge clock_in) sel = s[1:0];
         wait_c(4);
         probe(sel, 1'b0);
         bus_u.stop_c();
         probe(~sel, 1'b1);
         bus_u.stop_c();
      end
      // alert: change an input, restore it, change it again, then read
      dir_e = 8'hFF;
      bus_wr(8'h03, dir_e, 1'b1);
      bus_wr(8'h00, 8'h00, 1'b0);
      bus_rd(in_e());
      for (int k = 0; k < 3; k++) begin
         wait_c(10);
         ext = ext ^ 8'h10;
         wait_c(10);
         look({7'h00, k[0]}, {7'h00, al_oe_n});
      end
      bus_rd(in_e());
      wait_c(10);
      look(8'h01, {7'h00, al_oe_n});
      // reset pin in mid-run
      reset_n_in = 1'b0;
      wait_c(4);
      look(8'hFF, pin_out);
      reset_n_in = 1'b1;
      wait_c(20);
      bus_wr(8'h02, 8'h00, 1'b0);
      bus_rd(8'h00);
      wait (got_q.size() == 0);
      #100;
      wrap_up();
   end
endmodule
